// *** core/dpbr_ram.sv ***
// Our own choices: the address map.
`timescale 1ns/10ps
`default_nettype none
module dpbr_ram
  import dpbr_pkg::*;
#(
  parameter bit OUT_PIPE = 1'b0
) (
  input  wire logic        i_clock,
  input  wire logic        i_rstn,
  input  wire logic        i_fifo_mode,
  input  wire logic        i_split_read_write_mode,
  input  wire logic        i_half_mode,
  input  wire logic [1:0]  i_write_policy,
  input  wire logic [2:0]  i_a_width_sel,
  input  wire logic [2:0]  i_b_width_sel,
  input  wire logic        i_ecc_en,
  input  wire logic        i_cascade_upper,
  input  wire logic        i_a_en,
  input  wire logic        i_a_we,
  input  wire logic [15:0] i_a_addr,
  input  wire logic [71:0] i_a_wdata,
  output logic      [71:0] o_a_rdata,
  input  wire logic        i_b_en,
  input  wire logic        i_b_we,
  input  wire logic [15:0] i_b_addr,
  input  wire logic [71:0] i_b_wdata,
  output logic      [71:0] o_b_rdata,
  output logic             o_cascade_out,
  input  wire logic        i_cascade_in,
  input  wire logic [63:0] i_enc_data,
  output logic      [7:0]  o_enc_check,
  input  wire logic [71:0] i_dec_word,
  output logic      [63:0] o_dec_data,
  output logic             o_dec_sbit,
  output logic             o_dec_dbit,
  output logic             o_ecc_sbit,
  output logic             o_ecc_dbit,
  input  wire logic        i_fifo_fwft,
  input  wire logic [8:0]  i_afull_thresh,
  input  wire logic [8:0]  i_aempty_thresh,
  input  wire logic        i_fifo_wr,
  input  wire logic [71:0] i_fifo_wdata,
  input  wire logic        i_fifo_rd,
  output logic      [71:0] o_fifo_rdata,
  output logic             o_fifo_full,
  output logic             o_fifo_empty,
  output logic             o_fifo_afull,
  output logic             o_fifo_aempty
);
  // width select: 0=x1 1=x2 2=x4 3=x9 4=x18 5=x36 6=x72
  logic [71:0] mem_r [0:DPBR_CELL_DEPTH-1];
  // data bits fill the non power-of-two positions 3..71; check bit b covers position bit b
  function automatic logic [7:0] hamming_gen(input logic [63:0] d);
    logic [7:0] c;
    int         k;
    c = 8'h00;
    k = 0;
    for (int p = 1; p < 72; p++) begin
      if ((p & (p - 1)) != 0) begin
        for (int b = 0; b < 7; b++) begin
          if ((p & (1 << b)) != 0) begin
            c[b] = c[b] ^ d[k];
          end
        end
        k = k + 1;
      end
    end
    c[7] = ^{d, c[6:0]};
    return c;
  endfunction
  function automatic logic [65:0] hamming_fix(input logic [71:0] w);
    logic [7:0]  s;
    logic [63:0] d;
    logic        odd;
    int          k;
    d   = w[63:0];
    s   = hamming_gen(d) ^ w[71:64];
    // overall bit also covers the check bits, so fold their syndrome back in
    odd = s[7] ^ (^s[6:0]);
    k   = 0;
    for (int p = 1; p < 72; p++) begin
      if ((p & (p - 1)) != 0) begin
        if (odd && s[6:0] == 7'(p)) begin
          d[k] = ~d[k];
        end
        k = k + 1;
      end
    end
    return {odd, ~odd && s[6:0] != 7'h00, d};
  endfunction
  function automatic logic [6:0] lane_w(input logic [2:0] sel);
    unique case (sel)
      3'h0: lane_w = 7'd1;
      3'h1: lane_w = 7'd2;
      3'h2: lane_w = 7'd4;
      3'h3: lane_w = 7'd9;
      3'h4: lane_w = 7'd18;
      3'h5: lane_w = 7'd36;
      default: lane_w = 7'd72;
    endcase
  endfunction
  function automatic logic [2:0] eff_sel(input logic [2:0] sel, input logic srw,
                                         input logic half);
    logic [2:0] lim;
    lim = half ? (srw ? 3'h5 : 3'h4) : (srw ? 3'h6 : 3'h5);
    eff_sel = (sel > lim) ? lim : sel;
  endfunction
  logic [2:0] a_sel;
  logic [2:0] b_sel;
  assign a_sel = i_split_read_write_mode ? (i_half_mode ? 3'h5 : 3'h6)
                 : eff_sel(i_a_width_sel, 1'b0, i_half_mode);
  assign b_sel = eff_sel(i_b_width_sel, i_split_read_write_mode, i_half_mode);
  logic        a_en_r, a_we_r, b_en_r, b_we_r;
  logic [15:0] a_addr_r, b_addr_r;
  logic [71:0] a_wd_r, b_wd_r;
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      a_en_r <= 1'b0;
      a_we_r <= 1'b0;
      b_en_r <= 1'b0;
      b_we_r <= 1'b0;
      a_addr_r <= 16'h0000;
      b_addr_r <= 16'h0000;
      a_wd_r <= 72'h0;
      b_wd_r <= 72'h0;
    end else begin
      a_en_r <= i_a_en & ~i_fifo_mode;
      a_we_r <= i_a_we & ~i_split_read_write_mode;
      b_en_r <= i_b_en & ~i_fifo_mode;
      b_we_r <= i_b_we;
      a_addr_r <= i_a_addr;
      b_addr_r <= i_b_addr;
      a_wd_r <= i_a_wdata;
      b_wd_r <= i_b_wdata;
    end
  end
  // cascade: upper instance owns addr[15]; the lower one keeps bit 15 low
  logic a_hit, b_hit;
  assign a_hit = (a_sel != 3'h0) || (a_addr_r[15] == i_cascade_upper);
  assign b_hit = (b_sel != 3'h0) || (b_addr_r[15] == i_cascade_upper);
  // row and bit offset; half mode puts port b into the upper half
  function automatic logic [15:0] lane_base(input logic [15:0] a, input logic [2:0] s);
    logic [6:0] w;
    logic [15:0] idx;
    w = lane_w(s);
    unique case (s)
      3'h0: idx = {7'h00, a[5:0], 3'h0} / 16'd8;
      default: idx = 16'h0000;
    endcase
    lane_base = idx;
  endfunction
  function automatic logic [24:0] locate(input logic [15:0] a, input logic [2:0] s,
                                         input logic hi, input logic half);
    logic [6:0]  per;
    logic [15:0] row;
    logic [6:0]  off;
    logic [6:0]  w;
    w   = lane_w(s);
    per = (s == 3'h6) ? 7'd1 : ((s == 3'h5) ? 7'd2 : 7'd72 / w);
    row = 16'(({1'b0, a[14:0]}) / {9'h000, per});
    off = 7'((({1'b0, a[14:0]}) % {9'h000, per}) * {9'h000, w});
    if (half) begin
      row = {7'h00, hi, row[7:0]};
    end
    locate = {off, row[8:0], 9'h000} >> 9;
  endfunction
  logic [24:0] a_loc, b_loc;
  logic [15:0] unused_base;
  assign unused_base = lane_base(a_addr_r, a_sel);
  assign a_loc = locate(a_addr_r, a_sel, 1'b0, i_half_mode);
  assign b_loc = locate(b_addr_r, b_sel, i_half_mode, i_half_mode);
  function automatic logic [71:0] lane_mask(input logic [2:0] s, input logic [6:0] off);
    lane_mask = ((72'h1 << lane_w(s)) - 72'h1) << off;
  endfunction
  // queue pointers and flags
  localparam int FD = DPBR_CELL_DEPTH;
  logic [9:0]  wp_r, rp_r;
  logic [9:0]  cnt;
  logic        q_wr, q_rd, mem_rd;
  dpbr_fwft_e  fw_r;
  logic [71:0] fq_r;
  assign cnt = wp_r - rp_r;
  assign o_fifo_full  = i_fifo_mode && cnt == 10'(FD);
  logic mem_empty;
  assign mem_empty = cnt == 10'h000;
  assign q_wr = i_fifo_mode & i_fifo_wr & ~o_fifo_full;
  always_comb begin
    if (i_fifo_fwft) begin
      mem_rd = ~mem_empty && (fw_r == DPBR_FWFT_EMPTY ||
               (fw_r == DPBR_FWFT_SHOW && i_fifo_rd));
      o_fifo_empty = fw_r != DPBR_FWFT_SHOW;
    end else begin
      mem_rd = i_fifo_rd & ~mem_empty;
      o_fifo_empty = mem_empty;
    end
  end
  assign q_rd = i_fifo_mode & mem_rd;
  assign o_fifo_afull  = cnt >= {1'b0, i_afull_thresh};
  assign o_fifo_aempty = cnt <= {1'b0, i_aempty_thresh};
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      wp_r <= 10'h000;
      rp_r <= 10'h000;
    end else begin
      if (q_wr) wp_r <= wp_r + 10'h001;
      if (q_rd) rp_r <= rp_r + 10'h001;
    end
  end
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      fw_r <= DPBR_FWFT_EMPTY;
    end else if (!i_fifo_fwft) begin
      fw_r <= DPBR_FWFT_EMPTY;
    end else begin
      unique case (fw_r)
        DPBR_FWFT_EMPTY: if (q_rd) fw_r <= DPBR_FWFT_LOAD;
        DPBR_FWFT_LOAD:  fw_r <= DPBR_FWFT_SHOW;
        DPBR_FWFT_SHOW:  if (i_fifo_rd && !q_rd) fw_r <= DPBR_FWFT_EMPTY;
        default:         fw_r <= DPBR_FWFT_EMPTY;
      endcase
    end
  end
  // memory array access; queue borrows the full-width word, same width both sides
  logic [71:0] a_old, b_old, a_mask, b_mask, a_wdat, b_wdat;
  assign a_old = mem_r[a_loc[8:0]];
  assign b_old = mem_r[b_loc[8:0]];
  assign a_mask = lane_mask(a_sel, a_loc[15:9]);
  assign b_mask = lane_mask(b_sel, b_loc[15:9]);
  assign a_wdat = (i_ecc_en && a_sel == 3'h6) ?
                  {hamming_gen(a_wd_r[63:0]), a_wd_r[63:0]} : a_wd_r << a_loc[15:9];
  assign b_wdat = (i_ecc_en && b_sel == 3'h6) ?
                  {hamming_gen(b_wd_r[63:0]), b_wd_r[63:0]} : b_wd_r << b_loc[15:9];
  // port b wins a same-word collision; user must avoid it
  always_ff @(posedge i_clock) begin
    if (q_wr) begin
      mem_r[wp_r[8:0]] <= i_fifo_wdata;
    end else begin
      if (a_en_r && a_we_r && a_hit) mem_r[a_loc[8:0]] <= (a_old & ~a_mask) | (a_wdat & a_mask);
      if (b_en_r && b_we_r && b_hit) mem_r[b_loc[8:0]] <= (b_old & ~b_mask) | (b_wdat & b_mask);
    end
  end
  // output latch per port; holds between operations
  function automatic logic [71:0] rd_view(input logic [71:0] word, input logic [2:0] s,
                                          input logic [6:0] off, input logic ecc);
    logic [65:0] fx;
    fx = hamming_fix(word);
    if (ecc && s == 3'h6) rd_view = {8'h00, fx[63:0]};
    else rd_view = (word >> off) & ((72'h1 << lane_w(s)) - 72'h1);
  endfunction
  logic [71:0] a_q_r, b_q_r, a_p_r, b_p_r;
  logic [1:0]  err_r;
  logic        a_rd, b_rd;
  assign a_rd = a_en_r && a_hit && !(a_we_r && i_write_policy == DPBR_WM_NO_CHANGE);
  assign b_rd = b_en_r && b_hit && !(b_we_r && i_write_policy == DPBR_WM_NO_CHANGE);
  logic [65:0] b_fx;
  assign b_fx = hamming_fix(b_old);
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      a_q_r <= 72'h0;
      b_q_r <= 72'h0;
      err_r <= 2'b00;
    end else begin
      if (a_rd) begin
        a_q_r <= (a_we_r && i_write_policy == DPBR_WM_WRITE_FIRST) ?
                 (a_wd_r & ((72'h1 << lane_w(a_sel)) - 72'h1)) :
                 rd_view(a_old, a_sel, a_loc[15:9], i_ecc_en);
      end
      if (b_rd) begin
        b_q_r <= (b_we_r && i_write_policy == DPBR_WM_WRITE_FIRST) ?
                 (b_wd_r & ((72'h1 << lane_w(b_sel)) - 72'h1)) :
                 rd_view(b_old, b_sel, b_loc[15:9], i_ecc_en);
        err_r <= (i_ecc_en && b_sel == 3'h6) ? b_fx[65:64] : 2'b00;
      end
    end
  end
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      a_p_r <= 72'h0;
      b_p_r <= 72'h0;
      fq_r  <= 72'h0;
    end else begin
      a_p_r <= a_q_r;
      b_p_r <= b_q_r;
      if (q_rd) fq_r <= mem_r[rp_r[8:0]];
    end
  end
  assign o_a_rdata    = OUT_PIPE ? a_p_r : a_q_r;
  assign o_b_rdata    = OUT_PIPE ? b_p_r : b_q_r;
  assign o_fifo_rdata = fq_r;
  assign o_ecc_sbit   = err_r[1];
  assign o_ecc_dbit   = err_r[0];
  assign o_cascade_out = (a_sel == 3'h0) ? (i_cascade_upper ? o_a_rdata[0] : i_cascade_in)
                         : 1'b0;
  // standalone encoder and decoder for external wide memories
  logic [65:0] dec_fx;
  assign o_enc_check = hamming_gen(i_enc_data);
  assign dec_fx      = hamming_fix(i_dec_word);
  assign o_dec_data  = dec_fx[63:0];
  assign o_dec_sbit  = dec_fx[65];
  assign o_dec_dbit  = dec_fx[64];
  property p_fifo_no_over;
    @(posedge i_clock) disable iff (!i_rstn) cnt <= 10'(FD);
  endproperty
  a_fifo_no_over: assert property (p_fifo_no_over) else $error("queue overfilled");
  property p_full_blocks;
    @(posedge i_clock) disable iff (!i_rstn) o_fifo_full && i_fifo_wr |=> $stable(wp_r);
  endproperty
  a_full_blocks: assert property (p_full_blocks) else $error("write taken while full");
  property p_rd_hold;
    @(posedge i_clock) disable iff (!i_rstn) !a_rd |=> $stable(a_q_r);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("port a output moved");
  property p_pipe;
    @(posedge i_clock) disable iff (!i_rstn) OUT_PIPE |=> o_a_rdata == $past(a_q_r);
  endproperty
  a_pipe: assert property (p_pipe) else $error("pipeline latency wrong");
  property p_flags;
    @(posedge i_clock) disable iff (!i_rstn)
      i_fifo_mode && o_fifo_full |-> o_fifo_afull || i_afull_thresh > 9'h1FF;
  endproperty
  a_flags: assert property (p_flags) else $error("full without almost full");
  property p_enc;
    @(posedge i_clock) disable iff (!i_rstn)
      hamming_fix({o_enc_check, i_enc_data}) == {2'b00, i_enc_data};
  endproperty
  a_enc: assert property (p_enc) else $error("clean word flagged");
  property p_fwft;
    @(posedge i_clock) disable iff (!i_rstn)
      i_fifo_fwft && fw_r == DPBR_FWFT_LOAD |=> !o_fifo_empty;
  endproperty
  a_fwft: assert property (p_fwft) else $error("look-ahead word missing");
  property p_srw;
    @(posedge i_clock) disable iff (!i_rstn) i_split_read_write_mode |=> !a_we_r;
  endproperty
  a_srw: assert property (p_srw) else $error("read port wrote");
  c_full:  cover property (@(posedge i_clock) o_fifo_full);
  c_fwft:  cover property (@(posedge i_clock) fw_r == DPBR_FWFT_SHOW);
  property p_pipe_b;
    @(posedge i_clock) disable iff (!i_rstn) OUT_PIPE |=> o_b_rdata == $past(b_q_r);
  endproperty
  a_pipe_b: assert property (p_pipe_b) else $error("port b latency wrong");
  property p_empty_blocks;
    @(posedge i_clock) disable iff (!i_rstn)
      !i_fifo_fwft && o_fifo_empty && i_fifo_rd |=> $stable(rp_r);
  endproperty
  a_empty_blocks: assert property (p_empty_blocks) else $error("read while empty");
  c_write: cover property (@(posedge i_clock) a_en_r && a_we_r);
  c_ecc_fix: cover property (@(posedge i_clock) o_ecc_sbit);
  c_srw:     cover property (@(posedge i_clock) i_split_read_write_mode && a_en_r);
endmodule
`default_nettype wire

// *** core/dpbr_pkg.sv ***
package dpbr_pkg;
  localparam int DPBR_MEM_BITS     = 36864;
  localparam int DPBR_CELL_W       = 72;
  localparam int DPBR_CELL_DEPTH   = 512;
  localparam int DPBR_CELL_AW      = 9;
  localparam int DPBR_HALF_DEPTH   = 256;
  localparam int DPBR_DATA_W       = 64;
  localparam int DPBR_CHECK_W      = 8;
  localparam int DPBR_MAX_SEL_W    = 3;
  localparam int DPBR_PORT_AW      = 16;
  localparam int DPBR_FIFO_AW      = 9;
  localparam logic [1:0] DPBR_WM_READ_FIRST  = 2'h0;
  localparam logic [1:0] DPBR_WM_WRITE_FIRST = 2'h1;
  localparam logic [1:0] DPBR_WM_NO_CHANGE   = 2'h2;
  localparam logic [8:0] DPBR_AFULL_RST  = 9'h1F0;
  localparam logic [8:0] DPBR_AEMPTY_RST = 9'h010;
  typedef enum logic [1:0] {
    DPBR_FWFT_EMPTY = 2'b00,
    DPBR_FWFT_LOAD  = 2'b01,
    DPBR_FWFT_SHOW  = 2'b11
  } dpbr_fwft_e;
endpackage

// *** dv/dpbr_fabric_user.sv ***
`timescale 1ns/10ps
`default_nettype none
// fabric-side queue user: honours the flags unless told to misbehave
module dpbr_fabric_user (
  input  wire logic        i_push,
  input  wire logic        i_pop,
  input  wire logic        i_rude,
  input  wire logic [71:0] i_data,
  input  wire logic        i_full,
  input  wire logic        i_empty,
  output logic             o_wr,
  output logic             o_rd,
  output logic      [71:0] o_wdata
);
  assign o_wr    = i_push & (~i_full | i_rude);
  assign o_rd    = i_pop & (~i_empty | i_rude);
  // idle data is inverted so a stale word never looks valid
  assign o_wdata = o_wr ? i_data : ~i_data;
endmodule
`default_nettype wire

// *** dv/dual_port_block_ram_fifo_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module dual_port_block_ram_fifo_tb;
  import dpbr_pkg::*;
  logic        i_clock = 1'b0;
  logic        i_rstn  = 1'b0;
  logic        fmode = 0, fwft = 0, a_en = 0, a_we = 0, b_en = 0, b_we = 0;
  logic        push = 0, pop = 0, rude = 0;
  logic        srw = 0, ecc = 0;
  logic [15:0] ad;
  wire         esb, edb;
  logic [1:0]  pol   = DPBR_WM_READ_FIRST;
  logic [2:0]  wsel  = 3'h5;
  logic [15:0] a_ad  = '0, b_ad = '0;
  logic [71:0] a_wd  = '0, b_wd = '0, f_in = '0, dword = '0, r, v1, v2, vy, w;
  logic [63:0] enc   = '0;
  logic [8:0]  afth  = DPBR_AFULL_RST, aeth = DPBR_AEMPTY_RST;
  wire  [71:0] a_rd, b_rd, f_rd, f_wd;
  wire  [63:0] ddata;
  wire  [7:0]  echk;
  wire         full, empty, af, ae, wr, rd, ds, dd;
  int          n_errors = 0;
  int          n_tests  = 0;
  logic [71:0] q[$];
  logic [71:0] mem[int];

  always #5 i_clock = ~i_clock;

  dpbr_ram #(.OUT_PIPE(1'b1)) DUT (
    .i_clock(i_clock), .i_rstn(i_rstn), .i_fifo_mode(fmode),
    .i_split_read_write_mode(srw), .i_half_mode(1'b0), .i_write_policy(pol),
    .i_a_width_sel(wsel), .i_b_width_sel(wsel), .i_ecc_en(ecc), .i_cascade_upper(1'b0),
    .i_a_en(a_en), .i_a_we(a_we), .i_a_addr(a_ad), .i_a_wdata(a_wd), .o_a_rdata(a_rd),
    .i_b_en(b_en), .i_b_we(b_we), .i_b_addr(b_ad), .i_b_wdata(b_wd), .o_b_rdata(b_rd),
    .o_cascade_out(), .i_cascade_in(1'b0), .i_enc_data(enc), .o_enc_check(echk),
    .i_dec_word(dword), .o_dec_data(ddata), .o_dec_sbit(ds), .o_dec_dbit(dd),
    .o_ecc_sbit(esb), .o_ecc_dbit(edb), .i_fifo_fwft(fwft), .i_afull_thresh(afth),
    .i_aempty_thresh(aeth), .i_fifo_wr(wr), .i_fifo_wdata(f_wd), .i_fifo_rd(rd),
    .o_fifo_rdata(f_rd), .o_fifo_full(full), .o_fifo_empty(empty), .o_fifo_afull(af),
    .o_fifo_aempty(ae));

  dpbr_fabric_user user (
    .i_push(push), .i_pop(pop), .i_rude(rude), .i_data(f_in), .i_full(full),
    .i_empty(empty), .o_wr(wr), .o_rd(rd), .o_wdata(f_wd));

  task automatic chk(input logic [71:0] got, input logic [71:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic results;
    $display("errors=%0d tests=%0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // one access on port a or b; output pipeline on, so rdata is sampled two edges after the take
  task automatic acc(input bit b, input bit we, input logic [15:0] ad,
                     input logic [71:0] d, output logic [71:0] o);
    @(posedge i_clock);
    if (b) begin
      b_en <= 1; b_we <= we; b_ad <= ad; b_wd <= d;
    end else begin
      a_en <= 1; a_we <= we; a_ad <= ad; a_wd <= d;
    end
    @(posedge i_clock);
    a_en <= 0; b_en <= 0; a_we <= 0; b_we <= 0;
    repeat (2) @(posedge i_clock);
    #1 o = b ? b_rd : a_rd;
    if (we) mem[ad] = d;
  endtask

  task automatic fpush(input logic [71:0] d);
    @(posedge i_clock);
    push <= 1; f_in <= d;
    if (q.size() < 512 && !rude) q.push_back(d);
    @(posedge i_clock);
    push <= 0;
    #1;
  endtask

  task automatic fpop(output logic [71:0] o);
    @(posedge i_clock);
    pop <= 1;
    @(posedge i_clock);
    pop <= 0;
    #1 o = f_rd;
  endtask

  task automatic wait_rd(input logic [71:0] exp);
    int k = 0;
    while (f_rd !== exp && k < 8) begin
      @(posedge i_clock);
      #1 k++;
    end
    chk(f_rd, exp);
    if (k == 8) results();
  endtask

  function automatic logic [71:0] rnd36();
    return {36'h0, 4'($urandom), 32'($urandom)};
  endfunction

  initial begin
    void'($urandom(25));
    repeat (3) @(posedge i_clock);
    i_rstn <= 1'b1;
    #1 chk({empty, ae, full, af}, 4'hC);
    for (int i = 0; i < 8; i++) begin
      v1 = rnd36();
      ad = 16'($urandom_range(0, 1023));
      acc(i[0], 1, ad, v1, r);
      acc(!i[0], 0, ad, '0, r);
      chk(r, mem[ad]);
      repeat (3) @(posedge i_clock);
      #1 chk(i[0] ? a_rd : b_rd, v1);
    end
    for (int p = 0; p < 3; p++) begin
      @(posedge i_clock);
      pol <= 2'(p);
      v1 = rnd36(); v2 = rnd36(); vy = rnd36();
      acc(0, 1, 16'h10, v1, r);
      acc(0, 1, 16'h20, vy, r);
      acc(0, 0, 16'h20, '0, r);
      acc(0, 1, 16'h10, v2, r);
      chk(r, p == 0 ? v1 : (p == 1 ? v2 : vy));
    end
    for (int i = 0; i < 4; i++) begin
      @(posedge i_clock);
      enc <= {$urandom, $urandom};
      #1 w = {echk, enc};
      @(posedge i_clock);
      dword <= w ^ (72'h1 << $urandom_range(0, 71));
      #1 chk({ds, dd, ddata}, {2'b10, enc});
      @(posedge i_clock);
      dword <= w ^ (72'h3 << $urandom_range(0, 70));
      #1 chk({ds, dd}, 2'b01);
    end
    // split mode: port a is read-only at x72, port b writes with check bits
    @(posedge i_clock);
    srw <= 1; ecc <= 1; wsel <= 3'h6;
    v1 = {8'h00, $urandom, $urandom};
    acc(1, 1, 16'h30, v1, r);
    acc(0, 1, 16'h30, ~v1, r);
    acc(0, 0, 16'h30, '0, r);
    chk(r, v1);
    @(posedge i_clock);
    ecc <= 0;
    acc(1, 1, 16'h31, w ^ 72'h1, r);
    @(posedge i_clock);
    ecc <= 1;
    acc(1, 0, 16'h31, '0, r);
    chk(r, {8'h00, w[63:0]});
    chk({esb, edb}, 2'b10);
    @(posedge i_clock);
    srw <= 0; ecc <= 0; wsel <= 3'h5;
    @(posedge i_clock);
    fmode <= 1;
    for (int i = 0; i < 512; i++) begin
      fpush({8'($urandom), $urandom, $urandom});
      if (i == 255) chk({af, ae, full, empty}, 4'h0);
    end
    chk({full, af}, 2'b11);
    rude <= 1;
    fpush(72'h55);
    rude <= 0;
    for (int i = 0; i < 512; i++) begin
      fpop(r);
      chk(r, q.pop_front());
    end
    chk({empty, ae}, 2'b11);
    rude <= 1;
    fpop(r);
    rude <= 0;
    fpush(72'hA5);
    fpop(r);
    chk(r, q.pop_front());
    @(posedge i_clock);
    fwft <= 1;
    fpush(rnd36());
    fpush(rnd36());
    wait_rd(q.pop_front());
    fpop(r);
    wait_rd(q.pop_front());
    fpop(r);
    #1 chk(empty, 1'b1);
    results();
  end
endmodule
`default_nettype wire
